// *** hslc_cfg_if.sv ***
// Interface carrying per-channel coupling configuration to the combining core.
`timescale 1ns/1ps
interface hslc_cfg_if;
  hslc_pkg::hslc_chan_cfg_t cfg [5];
  logic [6:0]               ls_on;
  logic [4:0]               flag;
  modport regs (output cfg, output ls_on, input flag);
  modport core (input cfg, input ls_on, output flag);
endinterface

// *** hslc_combine.sv ***
// Combining core that forms each high-side channel's low-side-active flag.
`timescale 1ns/1ps
`include "hslc_consts.svh"
module hslc_combine (
  input  wire logic  clk,     // System clock.
  input  wire logic  rst,     // Asynchronous reset, active high.
  hslc_cfg_if.core   cfg_bus  // Configuration in, flags out.
);
  logic [4:0] flag_reg;
  logic [4:0] flag_next;

  always_comb begin
    for (int ch = 0; ch < `HSLC_NUM_HS; ch++) begin
      flag_next[ch] = (|(cfg_bus.cfg[ch][6:0] & cfg_bus.ls_on))  // [RULE1] [RULE3]
                      | cfg_bus.cfg[ch][`HSLC_DECOUPLE_BIT];     // [RULE2] [RULE4]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_reg <= 5'h00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign cfg_bus.flag = flag_reg;
endmodule

// *** hslc_consts.svh ***
// Register offsets, field positions, reset values and timing counts for the coupling block.
`ifndef HSLC_CONSTS_SVH
`define HSLC_CONSTS_SVH
`define HSLC_IDX_PAIR_A      12'h1A6
`define HSLC_IDX_PAIR_B      12'h1A7
`define HSLC_IDX_FIFTH       12'h1A8
`define HSLC_IDX_STATUS      12'h1B0
`define HSLC_IDX_LOCK        12'h1B1
`define HSLC_ADDR_W          14
`define HSLC_NUM_HS          5
`define HSLC_NUM_LS          7
`define HSLC_CHAN_W          8
`define HSLC_DECOUPLE_BIT    7
`define HSLC_CHAN_RESET      8'h7F
`define HSLC_RESP_OKAY       2'h0
`define HSLC_RESP_SLVERR     2'h2
`define HSLC_EXIT_TIME_NS    25
`define HSLC_CLK_PERIOD_NS   25
`define HSLC_EXIT_CYCLES     ((`HSLC_EXIT_TIME_NS + `HSLC_CLK_PERIOD_NS - 1) / `HSLC_CLK_PERIOD_NS)
`endif

// *** hslc_ls_model.sv ***
// Far side model: low-side drivers and bootstrap start requests.
`timescale 1ns/1ps
module hslc_ls_model (
  input  wire logic       clk,        // Clock.
  input  wire logic       rst,        // Reset.
  input  wire logic [6:0] ls_cmd,     // Requested low-side states.
  input  wire logic [4:0] start_cmd,  // Requested init entries.
  output logic      [6:0] ls_on,      // Low-side drivers on.
  output logic      [4:0] init_start  // Init entry pulse.
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ls_on <= 7'h00;
      init_start <= 5'h00;
    end else begin
      ls_on <= ls_cmd;
      // A held request gives a single-cycle pulse every other cycle.
      init_start <= start_cmd & ~init_start;
    end
  end
endmodule

// *** hslc_pkg.sv ***
// Types shared by the coupling block modules.
package hslc_pkg;
  typedef logic [7:0] hslc_chan_cfg_t;
  typedef enum logic [1:0] {HSLC_W_IDLE, HSLC_W_RESP} hslc_wstate_t;
  typedef enum logic [1:0] {HSLC_R_IDLE, HSLC_R_RESP} hslc_rstate_t;
endpackage

// *** hslc_tb_top.sv ***
// Self-checking testbench for the coupling block.
`timescale 1ns/1ps
`include "hslc_consts.svh"
module hslc_tb_top;
  logic        clk = 1'b0, rst = 1'b1;
  logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0, s;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, lock_m = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [4:0]  flag, init_exit, in_init, init_start, e, x, start_cmd = 5'h00;
  logic [6:0]  ls_on, ls_cmd = 7'h00;
  logic [7:0]  cfg [5] = '{5{`HSLC_CHAN_RESET}};
  logic [11:0] idx [3] = '{`HSLC_IDX_PAIR_A, `HSLC_IDX_PAIR_B, `HSLC_IDX_FIFTH};
  int          n_mismatch = 0, comparisons = 0, seed = 2985, i, k;
  hslc_top u_hslc_top (.SYS_CLK(clk), .RST(rst), .LS_ON(ls_on), .INIT_START(init_start),
    .LS_ACTIVE(flag), .INIT_EXIT(init_exit), .IN_INIT(in_init), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  hslc_ls_model u_hslc_ls_model (.clk(clk), .rst(rst), .ls_cmd(ls_cmd), .start_cmd(start_cmd),
    .ls_on(ls_on), .init_start(init_start));
  initial forever #12.5 clk = ~clk;
  task conclude;
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function logic [13:0] addr(input int r);
    return {idx[r], 2'b00};
  endfunction
  function logic [31:0] exp_reg(input int r);
    return (r == 2) ? {24'h0, cfg[4]} : {16'h0, cfg[2*r+1], cfg[2*r]};
  endfunction
  task mwr(input int r, input logic [31:0] v, input logic [3:0] b);
    if (!lock_m && b[0]) cfg[2*r] = v[7:0];
    if (!lock_m && b[1] && r < 2) cfg[2*r+1] = v[15:8];
  endtask
  task wr(input logic [13:0] a, input logic [31:0] v, input logic [3:0] b, input logic [1:0] er);
    logic ah, wh, bv, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= b;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($random(seed));
    while (!done) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bv = bvalid;
      done = bvalid && bready;
      if (done) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bv) bready <= !done;
    end
    @(posedge clk);
  endtask
  task rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, rv, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($random(seed));
    while (!done) begin
      @(negedge clk);
      ah = arvalid && arready;
      rv = rvalid;
      done = rvalid && rready;
      if (done) chk("rdata", ed, rdata);
      if (done) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rv) rready <= !done;
    end
    @(posedge clk);
  endtask
  task chk_flags;
    for (int c = 0; c < 5; c++) e[c] = |(cfg[c][6:0] & ls_cmd) | cfg[c][7];
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("flags", {27'h0, e}, {27'h0, flag});
    @(posedge clk);
    start_cmd <= 5'h1F;
    @(posedge clk);
    start_cmd <= 5'h00;
    x = 5'h00;
    repeat (4) begin
      @(negedge clk);
      x = x | init_exit;
      @(posedge clk);
    end
    @(negedge clk);
    chk("in_init", {27'h0, ~e}, {27'h0, in_init});
    chk("init_exit", {27'h0, e}, {27'h0, x});
    @(posedge clk);
    rd({`HSLC_IDX_STATUS, 2'b00}, {22'h0, ~e, e}, `HSLC_RESP_OKAY);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("in_init", 32'h1F, {27'h0, in_init});
    @(posedge clk);
    for (i = 0; i < 3; i++) rd(addr(i), exp_reg(i), `HSLC_RESP_OKAY);
    // All five channels are decoupled so that they leave initialization.
    for (i = 0; i < 3; i++) begin
      wr(addr(i), 32'h8080, 4'h3, `HSLC_RESP_OKAY);
      mwr(i, 32'h8080, 4'h3);
    end
    chk_flags;
    for (k = 0; k < 40; k++) begin
      i = {$random(seed)} % 3;
      d = $random(seed);
      s = {2'b00, 2'($random(seed))};
      ls_cmd <= 7'($random(seed));
      wr(addr(i), d, s, `HSLC_RESP_OKAY);
      mwr(i, d, s);
      rd(addr(i), exp_reg(i), `HSLC_RESP_OKAY);
      chk_flags;
    end
    wr(14'h0700, 32'hFFFF, 4'h3, `HSLC_RESP_SLVERR);
    rd(14'h0700, 32'h0, `HSLC_RESP_SLVERR);
    wr({`HSLC_IDX_LOCK, 2'b00}, 32'h1, 4'h1, `HSLC_RESP_OKAY);
    lock_m = 1'b1;
    rd({`HSLC_IDX_LOCK, 2'b00}, 32'h1, `HSLC_RESP_OKAY);
    wr(addr(0), ~exp_reg(0), 4'h3, `HSLC_RESP_OKAY);
    rd(addr(0), exp_reg(0), `HSLC_RESP_OKAY);
    conclude;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude;
  end
endmodule

// *** hslc_top.sv ***
// Coupling register bank with AXI4-Lite slave and bootstrap-exit tracking.
// Notes on behaviour
// [RULE1] A channel's flag rises when any coupled low-side driver is on.
// [RULE2] A set decouple bit forces the channel's flag to one.
// [RULE3] Software couples low side y to channel x only when they share a load.
// [RULE4] Decoupling cuts the channel's flag off from low-side activity.
// [RULE5] First pair register: channel 1 low byte, channel 2 high byte.
// [RULE6] Second pair register: channel 3 low byte, channel 4 high byte.
// [RULE7] Fifth register: channel 5 low byte, upper byte reserved, reads zero.
// [RULE8] A channel's bootstrap initialization ends once its flag is one.
// [RULE9] Software decouples every unused high-side driver to leave initialization.
// [RULE10] While the configuration lock is set, writes to coupling bits are ignored.
`timescale 1ns/1ps
`include "hslc_consts.svh"
module hslc_top (
  input  wire logic        SYS_CLK,        // System clock, 40 MHz.
  input  wire logic        RST,            // Asynchronous reset, active high.
  input  wire logic [6:0]  LS_ON,          // Low-side drivers currently switched on.
  input  wire logic [4:0]  INIT_START,     // Pulse: channel enters bootstrap initialization.
  output logic      [4:0]  LS_ACTIVE,      // Per-channel low-side-active flag.
  output logic      [4:0]  INIT_EXIT,      // Pulse: channel leaves initialization.
  output logic      [4:0]  IN_INIT,        // Channel still in initialization.
  input  wire logic [13:0] S_AXI_AWADDR,   // Write address.
  input  wire logic        S_AXI_AWVALID,  // Write address valid.
  output logic             S_AXI_AWREADY,  // Write address ready.
  input  wire logic [31:0] S_AXI_WDATA,    // Write data.
  input  wire logic [3:0]  S_AXI_WSTRB,    // Write byte strobes.
  input  wire logic        S_AXI_WVALID,   // Write data valid.
  output logic             S_AXI_WREADY,   // Write data ready.
  output logic [1:0]       S_AXI_BRESP,    // Write response.
  output logic             S_AXI_BVALID,   // Write response valid.
  input  wire logic        S_AXI_BREADY,   // Write response ready.
  input  wire logic [13:0] S_AXI_ARADDR,   // Read address.
  input  wire logic        S_AXI_ARVALID,  // Read address valid.
  output logic             S_AXI_ARREADY,  // Read address ready.
  output logic [31:0]      S_AXI_RDATA,    // Read data.
  output logic [1:0]       S_AXI_RRESP,    // Read response.
  output logic             S_AXI_RVALID,   // Read data valid.
  input  wire logic        S_AXI_RREADY    // Read data ready.
);
  hslc_cfg_if cfg_bus ();

  function automatic logic [11:0] word_index(input logic [13:0] addr);
    word_index = addr[13:2];
  endfunction

  function automatic logic mapped(input logic [11:0] idx);
    mapped = (idx == `HSLC_IDX_PAIR_A) || (idx == `HSLC_IDX_PAIR_B) ||
             (idx == `HSLC_IDX_FIFTH) || (idx == `HSLC_IDX_STATUS) ||
             (idx == `HSLC_IDX_LOCK);
  endfunction

  // Configuration and lock state.
  hslc_pkg::hslc_chan_cfg_t cfg_reg [5];
  hslc_pkg::hslc_chan_cfg_t cfg_next [5];
  logic                     lock_reg;
  logic                     lock_next;

  // Write channel state.
  hslc_pkg::hslc_wstate_t wstate_reg, wstate_next;
  logic                   aw_got_reg, aw_got_next;
  logic                   w_got_reg, w_got_next;
  logic [11:0]            widx_reg, widx_next;
  logic [31:0]            wdata_reg, wdata_next;
  logic [3:0]             wstrb_reg, wstrb_next;
  logic [1:0]             bresp_reg, bresp_next;

  // Read channel state.
  hslc_pkg::hslc_rstate_t rstate_reg, rstate_next;
  logic [31:0]            rdata_reg, rdata_next;
  logic [1:0]             rresp_reg, rresp_next;

  // Initialization tracking.
  logic [4:0] init_reg, init_next;
  logic [4:0] exit_reg, exit_next;

  logic aw_fire;
  logic w_fire;
  logic do_write;

  localparam hslc_pkg::hslc_wstate_t HSLC_W_IDLE_C = hslc_pkg::HSLC_W_IDLE;
  localparam hslc_pkg::hslc_wstate_t HSLC_W_RESP_C = hslc_pkg::HSLC_W_RESP;
  localparam hslc_pkg::hslc_rstate_t HSLC_R_IDLE_C = hslc_pkg::HSLC_R_IDLE;
  localparam hslc_pkg::hslc_rstate_t HSLC_R_RESP_C = hslc_pkg::HSLC_R_RESP;

  assign S_AXI_AWREADY = (wstate_reg == HSLC_W_IDLE_C) && !aw_got_reg;
  assign S_AXI_WREADY  = (wstate_reg == HSLC_W_IDLE_C) && !w_got_reg;
  assign aw_fire       = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire        = S_AXI_WVALID && S_AXI_WREADY;

  always_comb begin
    wstate_next = wstate_reg;
    aw_got_next = aw_got_reg || aw_fire;
    w_got_next  = w_got_reg || w_fire;
    widx_next   = aw_fire ? word_index(S_AXI_AWADDR) : widx_reg;
    wdata_next  = w_fire ? S_AXI_WDATA : wdata_reg;
    wstrb_next  = w_fire ? S_AXI_WSTRB : wstrb_reg;
    bresp_next  = bresp_reg;
    do_write    = 1'b0;
    unique case (wstate_reg)
      HSLC_W_IDLE_C: begin
        if (aw_got_next && w_got_next) begin
          do_write    = 1'b1;
          bresp_next  = mapped(widx_next) ? `HSLC_RESP_OKAY : `HSLC_RESP_SLVERR;
          wstate_next = HSLC_W_RESP_C;
          aw_got_next = 1'b0;
          w_got_next  = 1'b0;
        end
      end
      HSLC_W_RESP_C: begin
        if (S_AXI_BREADY) begin
          wstate_next = HSLC_W_IDLE_C;
        end
      end
      default: wstate_next = HSLC_W_IDLE_C;
    endcase
  end

  // Register writes; the byte strobe selects which channel byte changes.
  always_comb begin
    logic [31:0] d;
    logic [3:0]  s;
    d         = w_fire ? S_AXI_WDATA : wdata_reg;
    s         = w_fire ? S_AXI_WSTRB : wstrb_reg;
    lock_next = lock_reg;
    for (int ch = 0; ch < `HSLC_NUM_HS; ch++) begin
      cfg_next[ch] = cfg_reg[ch];
    end
    if (do_write) begin
      if (!lock_reg) begin  // [RULE10]
        unique case (widx_next)
          `HSLC_IDX_PAIR_A: begin  // [RULE5]
            if (s[0]) cfg_next[0] = d[7:0];
            if (s[1]) cfg_next[1] = d[15:8];
          end
          `HSLC_IDX_PAIR_B: begin  // [RULE6]
            if (s[0]) cfg_next[2] = d[7:0];
            if (s[1]) cfg_next[3] = d[15:8];
          end
          `HSLC_IDX_FIFTH: begin  // [RULE7]
            if (s[0]) cfg_next[4] = d[7:0];
          end
          default: ;
        endcase
      end
      if ((widx_next == `HSLC_IDX_LOCK) && s[0]) begin
        lock_next = d[0] | lock_reg;
      end
    end
  end

  always_comb begin
    rstate_next = rstate_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    unique case (rstate_reg)
      HSLC_R_IDLE_C: begin
        if (S_AXI_ARVALID) begin
          rstate_next = HSLC_R_RESP_C;
          rresp_next  = mapped(word_index(S_AXI_ARADDR)) ? `HSLC_RESP_OKAY
                                                         : `HSLC_RESP_SLVERR;
          unique case (word_index(S_AXI_ARADDR))
            `HSLC_IDX_PAIR_A: rdata_next = {16'h0000, cfg_reg[1], cfg_reg[0]};
            `HSLC_IDX_PAIR_B: rdata_next = {16'h0000, cfg_reg[3], cfg_reg[2]};
            `HSLC_IDX_FIFTH:  rdata_next = {24'h000000, cfg_reg[4]};  // [RULE7]
            `HSLC_IDX_STATUS: rdata_next = {22'h000000, init_reg, cfg_bus.flag};
            `HSLC_IDX_LOCK:   rdata_next = {31'h00000000, lock_reg};
            default:          rdata_next = 32'h00000000;
          endcase
        end
      end
      HSLC_R_RESP_C: begin
        if (S_AXI_RREADY) begin
          rstate_next = HSLC_R_IDLE_C;
        end
      end
      default: rstate_next = HSLC_R_IDLE_C;
    endcase
  end

  // Initialization ends on the flag; a start in the same cycle keeps the channel in it.
  always_comb begin
    for (int ch = 0; ch < `HSLC_NUM_HS; ch++) begin
      exit_next[ch] = init_reg[ch] && cfg_bus.flag[ch] && !INIT_START[ch];  // [RULE8] [RULE9]
      init_next[ch] = (init_reg[ch] && !cfg_bus.flag[ch]) || INIT_START[ch];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      for (int ch = 0; ch < `HSLC_NUM_HS; ch++) begin
        cfg_reg[ch] <= `HSLC_CHAN_RESET;
      end
      lock_reg   <= 1'b0;
      wstate_reg <= HSLC_W_IDLE_C;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      widx_reg   <= 12'h000;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
      bresp_reg  <= 2'h0;
      rstate_reg <= HSLC_R_IDLE_C;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= 2'h0;
      init_reg   <= 5'h1F;
      exit_reg   <= 5'h00;
    end else begin
      cfg_reg    <= cfg_next;
      lock_reg   <= lock_next;
      wstate_reg <= wstate_next;
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      widx_reg   <= widx_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      bresp_reg  <= bresp_next;
      rstate_reg <= rstate_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
      init_reg   <= init_next;
      exit_reg   <= exit_next;
    end
  end

  assign cfg_bus.cfg   = cfg_reg;
  assign cfg_bus.ls_on = LS_ON;

  hslc_combine u_combine (
    .clk     (SYS_CLK),
    .rst     (RST),
    .cfg_bus (cfg_bus)
  );

  assign LS_ACTIVE     = cfg_bus.flag;
  assign INIT_EXIT     = exit_reg;
  assign IN_INIT       = init_reg;
  assign S_AXI_BVALID  = (wstate_reg == HSLC_W_RESP_C);
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = (rstate_reg == HSLC_R_IDLE_C);
  assign S_AXI_RVALID  = (rstate_reg == HSLC_R_RESP_C);
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
endmodule

// *** hslc_top_chk.sv ***
// Port assertions for the coupling block.
`timescale 1ns/1ps
module hslc_top_chk (
  input wire logic        SYS_CLK,     // Clock.
  input wire logic        RST,         // Reset.
  input wire logic [4:0]  INIT_START,  // Init entry.
  input wire logic [4:0]  INIT_EXIT,   // Exit pulses.
  input wire logic [4:0]  IN_INIT,     // Init state.
  input wire logic [4:0]  LS_ACTIVE,   // Flags.
  input wire logic        S_AXI_BVALID, // Write response valid.
  input wire logic        S_AXI_BREADY, // Write response ready.
  input wire logic [1:0]  S_AXI_BRESP,  // Write response.
  input wire logic        S_AXI_ARVALID, // Read address valid.
  input wire logic        S_AXI_ARREADY, // Read address ready.
  input wire logic        S_AXI_RVALID, // Read valid.
  input wire logic        S_AXI_RREADY, // Read ready.
  input wire logic [31:0] S_AXI_RDATA   // Read data.
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_exit_prompt: assert property ((IN_INIT & LS_ACTIVE & ~INIT_START) != 5'h00 |=>
    (IN_INIT & $past(IN_INIT & LS_ACTIVE & ~INIT_START)) == 5'h00) else $error("init not left");
  a_exit_cause: assert property ((INIT_EXIT & ~($past(IN_INIT) & ~IN_INIT)) == 5'h00)
    else $error("exit pulse without leaving init");
  a_start_enters: assert property (INIT_START != 5'h00 |=>
    (IN_INIT & $past(INIT_START)) == $past(INIT_START)) else $error("init not entered");
  a_exit_single: assert property ((INIT_EXIT & $past(INIT_EXIT)) == 5'h00)
    else $error("exit pulse too long");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address accepted during response");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  c_exit: cover property (INIT_EXIT != 5'h00);
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind hslc_top hslc_top_chk u_hslc_top_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .INIT_START(INIT_START), .INIT_EXIT(INIT_EXIT), .IN_INIT(IN_INIT), .LS_ACTIVE(LS_ACTIVE),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));
